// >>> pkg/lpes_map.svh
// offsets, bit positions, widths and reset values of the link/phy event status block
//
// What this block does
// R1: writing one to a set status bit clears it, acknowledging the event
// R2: writing one to a status bit already zero changes nothing
// R3: an enable register mirrors the status bit layout one for one
// R4: every status condition can raise an interrupt when its enable is set
// R5: set command-reset-received when a write to RESET-START arrives
// R6: set fair-gap when the bus idles for a subaction gap
// R7: set arbitration-reset-gap when the bus idles for an arbitration reset gap
// R8: set phy-interrupt when the physical device signals an interrupt
// R9: set phy-register-received when the physical device delivers a register
// R10: bus reset start sets its flag and clears node identity valid
// R11: set transmitter-ready when the transmitter becomes idle
// R12: set receiver-has-data when the receiver commits data; diagnostic only
// R13: set isochronous-stuck on invalid transmit data with isochronous FIFO selected
// R14: set asynchronous-stuck on unexpected async data; software resets transmitter
// R15: status bits latch on their event and hold until acknowledged
// R16: enable one passes interrupt; zero blocks it, status stays readable
// R17: node identity valid accepts own packets; sets after self-id completes
// R18: one interrupt request is the OR of status AND enable
`ifndef LPES_MAP_SVH
`define LPES_MAP_SVH

`define LPES_ADDR_W           8
`define LPES_DATA_W           32
`define LPES_EVT_WIDTH        19

`define LPES_OFF_STATUS       8'h08
`define LPES_OFF_ENABLE       8'h0C

`define LPES_BIT_CMD_RESET    18
`define LPES_BIT_FAIR_GAP     17
`define LPES_BIT_ARB_GAP      16
`define LPES_BIT_PHY_INT      15
`define LPES_BIT_PHY_REG      14
`define LPES_BIT_BUS_RESET    13
`define LPES_BIT_TX_READY     12
`define LPES_BIT_RX_DATA      11
`define LPES_BIT_ISO_STUCK    10
`define LPES_BIT_ASYNC_STUCK  9

`define LPES_STATUS_RST       1'b0
`define LPES_ENABLE_RST       19'h00000
`define LPES_RDATA_RST        32'h00000000
`define LPES_NODE_IDENTITY_VALID_RST      1'b0

`endif

// >>> pkg/lpes_pkg.sv
// state types of the link/phy event status block
`include "lpes_map.svh"

package lpes_pkg;

  typedef struct packed {
    logic status;
  } lpes_bit_state_t;

  typedef struct packed {
    logic [`LPES_EVT_WIDTH-1:0] enable;
    logic [`LPES_DATA_W-1:0]    rdata;
    logic                       irq;
    logic                       node_valid;
  } lpes_top_state_t;

endpackage

// >>> logic/lpes_event_bit.sv
// one sticky write-one-to-clear event bit with its enable gate
`include "lpes_map.svh"

module lpes_event_bit (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  input  wire logic enable_i,
  output logic      status_o,
  output logic      pend_o
);

  lpes_pkg::lpes_bit_state_t state_reg;
  lpes_pkg::lpes_bit_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // set beats clear so an event in the acknowledge cycle is kept
    if (set_i) begin
      state_next.status = 1'b1; // R15
    end else if (clear_i) begin
      state_next.status = 1'b0; // R1
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '{status: `LPES_STATUS_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  assign status_o = state_reg.status;
  assign pend_o   = state_reg.status & enable_i; // R16

endmodule // lpes_event_bit

// >>> logic/lpes_event_status.sv
// link/phy event status and enable registers with interrupt request
`include "lpes_map.svh"

module lpes_event_status (
  input  wire logic                     mclk_i,
  input  wire logic                     resetn_i,
  input  wire logic [`LPES_ADDR_W-1:0]  reg_addr_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [`LPES_DATA_W-1:0]  reg_wdata_i,
  output logic      [`LPES_DATA_W-1:0]  reg_rdata_o,
  input  wire logic                     evt_cmd_reset_i,
  input  wire logic                     evt_fair_gap_i,
  input  wire logic                     evt_arb_gap_i,
  input  wire logic                     evt_phy_int_i,
  input  wire logic                     evt_phy_reg_i,
  input  wire logic                     evt_bus_reset_i,
  input  wire logic                     evt_tx_ready_i,
  input  wire logic                     evt_rx_data_i,
  input  wire logic                     evt_iso_stuck_i,
  input  wire logic                     evt_async_stuck_i,
  input  wire logic                     selfid_done_i,
  output logic                          node_identity_valid_o,
  output logic                          irq_o
);

  localparam int EW = `LPES_EVT_WIDTH;

  lpes_pkg::lpes_top_state_t state_reg;
  lpes_pkg::lpes_top_state_t state_next;

  logic [EW-1:0] evt_vec;
  logic [EW-1:0] clr_vec;
  logic [EW-1:0] status_vec;
  logic [EW-1:0] pend_vec;
  logic          wr_status;
  logic          wr_enable;

  ////////////////////////////////////////////////////////////////////////////
  // event collection

  always_comb begin
    evt_vec                         = '0;
    evt_vec[`LPES_BIT_CMD_RESET]    = evt_cmd_reset_i;   // R5
    evt_vec[`LPES_BIT_FAIR_GAP]     = evt_fair_gap_i;    // R6
    evt_vec[`LPES_BIT_ARB_GAP]      = evt_arb_gap_i;     // R7
    evt_vec[`LPES_BIT_PHY_INT]      = evt_phy_int_i;     // R8
    evt_vec[`LPES_BIT_PHY_REG]      = evt_phy_reg_i;     // R9
    evt_vec[`LPES_BIT_BUS_RESET]    = evt_bus_reset_i;   // R10
    evt_vec[`LPES_BIT_TX_READY]     = evt_tx_ready_i;    // R11
    evt_vec[`LPES_BIT_RX_DATA]      = evt_rx_data_i;     // R12
    evt_vec[`LPES_BIT_ISO_STUCK]    = evt_iso_stuck_i;   // R13
    evt_vec[`LPES_BIT_ASYNC_STUCK]  = evt_async_stuck_i; // R14
  end

  assign wr_status = reg_wr_i && (reg_addr_i == `LPES_OFF_STATUS);
  assign wr_enable = reg_wr_i && (reg_addr_i == `LPES_OFF_ENABLE);
  // a one on a bit already zero only reaches a clear input, so nothing moves
  assign clr_vec   = wr_status ? reg_wdata_i[EW-1:0] : '0; // R2

  ////////////////////////////////////////////////////////////////////////////
  // status bits; unused positions never see a set and read zero

  for (genvar g = 0; g < EW; g++) begin : g_bit
    lpes_event_bit u_bit (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .set_i    (evt_vec[g]),
      .clear_i  (clr_vec[g]),
      .enable_i (state_reg.enable[g]),
      .status_o (status_vec[g]),
      .pend_o   (pend_vec[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, read data, node identity and interrupt

  always_comb begin
    state_next = state_reg;
    if (wr_enable) begin
      state_next.enable = reg_wdata_i[EW-1:0]; // R3
    end
    if (reg_rd_i) begin
      // status reads back regardless of its enable
      if (reg_addr_i == `LPES_OFF_STATUS) begin
        state_next.rdata = {{(`LPES_DATA_W-EW){1'b0}}, status_vec}; // R16
      end else if (reg_addr_i == `LPES_OFF_ENABLE) begin
        state_next.rdata = {{(`LPES_DATA_W-EW){1'b0}}, state_reg.enable};
      end else begin
        state_next.rdata = `LPES_RDATA_RST;
      end
    end
    // bus reset wins: a stale self-id must not revalidate a node id
    if (evt_bus_reset_i) begin
      state_next.node_valid = 1'b0; // R10
    end else if (selfid_done_i) begin
      state_next.node_valid = 1'b1; // R17
    end
    state_next.irq = |pend_vec; // R18 R4
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '{enable:     `LPES_ENABLE_RST,
                     rdata:      `LPES_RDATA_RST,
                     irq:        1'b0,
                     node_valid: `LPES_NODE_IDENTITY_VALID_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_o           = state_reg.rdata;
  assign node_identity_valid_o = state_reg.node_valid;
  assign irq_o                 = state_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_ack_clears;
    wr_status && reg_wdata_i[`LPES_BIT_CMD_RESET] && !evt_cmd_reset_i
      |=> !status_vec[`LPES_BIT_CMD_RESET];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("acknowledged bit did not clear"); // R1

  property p_zero_write_keeps;
    wr_status && !reg_wdata_i[`LPES_BIT_FAIR_GAP] && status_vec[`LPES_BIT_FAIR_GAP]
      |=> status_vec[`LPES_BIT_FAIR_GAP];
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write changed a bit"); // R2

  property p_enable_mirror;
    wr_enable |=> state_reg.enable == $past(reg_wdata_i[EW-1:0]);
  endproperty
  a_enable_mirror: assert property (p_enable_mirror) else $error("enable write not stored"); // R3

  property p_irq_follows;
    (|(status_vec & state_reg.enable)) |=> irq_o;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("enabled event gave no interrupt"); // R4

  property p_irq_blocked;
    !(|(status_vec & state_reg.enable)) |=> !irq_o;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked) else $error("interrupt without enabled event"); // R18

  property p_cmd_reset_set;
    evt_cmd_reset_i |=> status_vec[`LPES_BIT_CMD_RESET];
  endproperty
  a_cmd_reset_set: assert property (p_cmd_reset_set) else $error("command reset flag not set"); // R5

  property p_gap_set;
    evt_fair_gap_i && evt_arb_gap_i |=> status_vec[`LPES_BIT_FAIR_GAP] && status_vec[`LPES_BIT_ARB_GAP];
  endproperty
  a_gap_set: assert property (p_gap_set) else $error("gap flags not set"); // R6 R7

  property p_phy_set;
    evt_phy_int_i ##0 evt_phy_reg_i |=> status_vec[`LPES_BIT_PHY_INT] && status_vec[`LPES_BIT_PHY_REG];
  endproperty
  a_phy_set: assert property (p_phy_set) else $error("phy flags not set"); // R8 R9

  property p_bus_reset;
    evt_bus_reset_i |=> status_vec[`LPES_BIT_BUS_RESET] && !node_identity_valid_o;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset flag or node valid wrong"); // R10

  property p_xfer_set;
    evt_tx_ready_i || evt_rx_data_i |=> $past(evt_tx_ready_i) == ($past(evt_tx_ready_i) &&
      status_vec[`LPES_BIT_TX_READY]) && (!$past(evt_rx_data_i) || status_vec[`LPES_BIT_RX_DATA]);
  endproperty
  a_xfer_set: assert property (p_xfer_set) else $error("transfer flag not set"); // R11 R12

  property p_stuck_set;
    evt_iso_stuck_i || evt_async_stuck_i |=>
      (!$past(evt_iso_stuck_i) || status_vec[`LPES_BIT_ISO_STUCK]) &&
      (!$past(evt_async_stuck_i) || status_vec[`LPES_BIT_ASYNC_STUCK]);
  endproperty
  a_stuck_set: assert property (p_stuck_set) else $error("stuck flag not set"); // R13 R14

  // one cycle only: the next cycle may carry a legal acknowledge
  property p_hold;
    status_vec[`LPES_BIT_ARB_GAP] && !wr_status |=> status_vec[`LPES_BIT_ARB_GAP];
  endproperty
  a_hold: assert property (p_hold) else $error("latched bit dropped"); // R15

  property p_set_wins;
    wr_status && reg_wdata_i[`LPES_BIT_PHY_INT] && evt_phy_int_i |=> status_vec[`LPES_BIT_PHY_INT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in acknowledge cycle"); // R15

  property p_enable_hold;
    !wr_enable |=> $stable(state_reg.enable);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed without write"); // R3

  property p_reserved_zero;
    reg_rd_i && (reg_addr_i == `LPES_OFF_STATUS)
      |=> reg_rdata_o[`LPES_DATA_W-1:EW] == '0 && reg_rdata_o[`LPES_BIT_ASYNC_STUCK-1:0] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("unused status bits not zero"); // R16

  property p_read_holds;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_read_holds: assert property (p_read_holds) else $error("read data moved without read"); // R16

  property p_node_valid_hold;
    !evt_bus_reset_i && !selfid_done_i |=> $stable(node_identity_valid_o);
  endproperty
  a_node_valid_hold: assert property (p_node_valid_hold) else $error("node valid moved unprompted"); // R17

  property p_status_readable;
    reg_rd_i && (reg_addr_i == `LPES_OFF_STATUS) && !wr_status && evt_vec == '0
      |=> reg_rdata_o[EW-1:0] == status_vec;
  endproperty
  a_status_readable: assert property (p_status_readable) else $error("status read mismatch"); // R16

  property p_node_valid_set;
    selfid_done_i && !evt_bus_reset_i |=> node_identity_valid_o;
  endproperty
  a_node_valid_set: assert property (p_node_valid_set) else $error("node valid not set"); // R17

endmodule // lpes_event_status

// >>> dv/lpes_event_status_tb.sv
// self-checking bench for the link/phy event status block
`include "lpes_map.svh"

module lpes_event_status_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    mclk_i        = 1'b0;
  logic                    resetn_i      = 1'b0;
  logic                    reg_wr_i      = 1'b0;
  logic                    reg_rd_i      = 1'b0;
  logic                    selfid_done_i = 1'b0;
  logic [`LPES_ADDR_W-1:0] reg_addr_i    = 8'h00;
  logic [`LPES_DATA_W-1:0] reg_wdata_i   = 32'h00000000;
  logic [9:0]              evt           = 10'h000;
  logic [`LPES_DATA_W-1:0] reg_rdata_o;
  logic                    node_identity_valid_o;
  logic                    irq_o;
  logic [18:0]             st_m          = 19'h00000;
  logic [18:0]             en_m          = 19'h00000;
  logic                    nv_m          = 1'b0;
  logic                    rd_seen       = 1'b0;
  logic [33:0]             note;
  logic [33:0]             notes[$];
  logic [31:0]             rdat          = 32'h00000000;
  logic [31:0]             rng           = 32'h0000002F;
  logic [7:0]              addrs[4]      = '{8'h08, 8'h0C, 8'h04, 8'h10};
  int                      mismatches    = 0;
  int                      samples_checked = 0;
  int                      cycles        = 0;

  lpes_event_status u_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .evt_cmd_reset_i(evt[9]), .evt_fair_gap_i(evt[8]), .evt_arb_gap_i(evt[7]), .evt_phy_int_i(evt[6]),
    .evt_phy_reg_i(evt[5]), .evt_bus_reset_i(evt[4]), .evt_tx_ready_i(evt[3]), .evt_rx_data_i(evt[2]),
    .evt_iso_stuck_i(evt[1]), .evt_async_stuck_i(evt[0]), .selfid_done_i(selfid_done_i),
    .node_identity_valid_o(node_identity_valid_o), .irq_o(irq_o)
  );

  always #5 mclk_i = ~mclk_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task results();
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one bus/event cycle; the note holds the pre-edge view the read returns
  task step(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d,
            input logic [9:0] e, input logic s);
    logic [31:0] rd;
    rd = (a == `LPES_OFF_STATUS) ? {13'h0, st_m} : (a == `LPES_OFF_ENABLE) ? {13'h0, en_m} : 32'h00000000;
    // node flag lands on the read edge itself, so its note takes this cycle's events
    if (r) notes.push_back({rd, |(st_m & en_m), e[4] ? 1'b0 : (s ? 1'b1 : nv_m)});
    if (w && a == `LPES_OFF_STATUS) st_m = st_m & ~d[18:0];
    st_m = st_m | {e, 9'h000};
    if (w && a == `LPES_OFF_ENABLE) en_m = d[18:0];
    nv_m = e[4] ? 1'b0 : (s ? 1'b1 : nv_m);
    reg_wr_i      <= w;
    reg_rd_i      <= r;
    reg_addr_i    <= a;
    reg_wdata_i   <= d;
    evt           <= e;
    selfid_done_i <= s;
    @(posedge mclk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    rd_seen <= reg_rd_i;
    cycles  <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      $display("BAD %0t run timed out", $time);
      results();
    end
  end

  // answer stands from the edge after the read; sampled mid-cycle
  always @(negedge mclk_i) begin
    if (rd_seen) begin
      samples_checked++;
      if (notes.size() == 0) begin
        mismatches++;
        $display("BAD %0t read answer with no note", $time);
      end else begin
        note = notes.pop_front();
        if ({reg_rdata_o, irq_o, node_identity_valid_o} !== note) begin
          mismatches++;
          $display("BAD %0t read got %h expected %h", $time, {reg_rdata_o, irq_o, node_identity_valid_o}, note);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    step(1'b0, 1'b1, 8'h08, 32'h00000000, 10'h000, 1'b0);
    step(1'b0, 1'b1, 8'h0C, 32'h00000000, 10'h000, 1'b0);
    step(1'b1, 1'b1, 8'h0C, 32'h0007FFFF, 10'h000, 1'b0);
    for (int i = 0; i < 10; i++) begin
      step(1'b0, 1'b0, 8'h00, 32'h00000000, 10'h001 << i, 1'b0);
      step(1'b0, 1'b1, 8'h08, 32'h00000000, 10'h000, 1'b0);
      step(1'b1, 1'b1, 8'h08, 32'h00000001 << (9 + i), 10'h000, 1'b0);
      step(1'b1, 1'b1, 8'h08, 32'hFFFFFFFF, 10'h000, 1'b0);
    end
    // masked events still read back, with no request
    step(1'b1, 1'b0, 8'h0C, 32'h00000000, 10'h000, 1'b0);
    step(1'b0, 1'b0, 8'h00, 32'h00000000, 10'h3FF, 1'b0);
    step(1'b1, 1'b1, 8'h08, 32'hFFFFFFFF, 10'h3FF, 1'b0);
    step(1'b0, 1'b1, 8'h08, 32'h00000000, 10'h000, 1'b1);
    step(1'b0, 1'b1, 8'h08, 32'h00000000, 10'h010, 1'b1);
    for (int i = 0; i < 300; i++) begin
      rng = xs(rng);
      rdat = xs(rng);
      step(rng[0], rng[1] | rng[2], addrs[rng[4:3]], rdat, rng[14:5] & rng[24:15] & rdat[9:0],
           rng[30] & rng[31]);
    end
    step(1'b0, 1'b0, 8'h00, 32'h00000000, 10'h000, 1'b0);
    repeat (3) @(posedge mclk_i);
    if (notes.size() != 0) begin
      mismatches++;
      $display("BAD %0t %0d read notes left unanswered", $time, notes.size());
    end
    results();
  end

endmodule // lpes_event_status_tb
